/* File: hdl/tsec_defines.svh */
// Register offsets, field layouts, reset values and counts of the two-stage event controller.
`ifndef TSEC_DEFINES_SVH
`define TSEC_DEFINES_SVH
`define TSEC_ADDR_W 12
`define TSEC_OFF_LATCH 12'h000
`define TSEC_OFF_MASK 12'h004
`define TSEC_OFF_PEND 12'h008
`define TSEC_OFF_PMASK 12'h00C
`define TSEC_OFF_PSTAT 12'h010
`define TSEC_OFF_PWAKE 12'h014
`define TSEC_OFF_GIE 12'h018
`define TSEC_OFF_ASSIGN0 12'h020
`define TSEC_OFF_ASSIGN1 12'h024
`define TSEC_OFF_ASSIGN2 12'h028
`define TSEC_OFF_ASSIGN3 12'h02C
`define TSEC_NUM_LEVELS 9
`define TSEC_LEVEL_BASE 7
`define TSEC_NO_LEVEL 4'h9
`define TSEC_FIELD_W 4
`define TSEC_ASSIGN_REGS 4
`define TSEC_RST_ASSIGN0 32'h2221_1000
`define TSEC_RST_ASSIGN1 32'h4333_3332
`define TSEC_RST_ASSIGN2 32'h5555_5444
`define TSEC_RST_ASSIGN3 32'h6665_5555
`define TSEC_RST_LEVELS 9'h000
`define TSEC_RST_WORD 32'h0000_0000
`define TSEC_RST_GIE 1'b0
`endif

/* File: hdl/tsec_level_map.sv */
// Routing of peripheral interrupt IDs onto the general-purpose core levels.
`timescale 1ns/100ps
`default_nettype none
`include "tsec_defines.svh"
module tsec_level_map #(
  parameter int NUM_IDS = 32
) (
  // Peripheral side.
  input wire logic [NUM_IDS-1:0] periph_irq,
  input wire logic [NUM_IDS-1:0] peripheral_irq_mask,
  // Level selected for each ID, one field per ID.
  input wire logic [NUM_IDS*`TSEC_FIELD_W-1:0] assign_map,
  // One request level per general-purpose core level.
  output logic [`TSEC_NUM_LEVELS-1:0] level_raw
);
  // Each level ORs every unmasked ID routed to it, so shared IDs merge here.
  for (genvar lv = 0; lv < `TSEC_NUM_LEVELS; lv++) begin : g_level
    logic [NUM_IDS-1:0] hit;
    for (genvar id = 0; id < NUM_IDS; id++) begin : g_id
      assign hit[id] = periph_irq[id] & peripheral_irq_mask[id] &
                       (assign_map[id*`TSEC_FIELD_W +: `TSEC_FIELD_W] ==
                        `TSEC_FIELD_W'(lv));
    end
    assign level_raw[lv] = |hit;
  end
endmodule
`default_nettype wire

/* File: hdl/tsec_pkg.sv */
// Types shared by the two-stage event controller files.
`include "tsec_defines.svh"
package tsec_pkg;
  // Bus answer phase: one wait cycle, then the answer.
  typedef enum logic {
    TSEC_BUS_WAIT = 1'b0,
    TSEC_BUS_ANSWER = 1'b1
  } tsec_bus_t;

  // Whole state of the controller, registered in one place.
  typedef struct packed {
    tsec_bus_t bus;
    logic [31:0] prdata;
    logic pslverr;
    logic [`TSEC_NUM_LEVELS-1:0] latch;
    logic [`TSEC_NUM_LEVELS-1:0] mask;
    logic [`TSEC_NUM_LEVELS-1:0] pend;
    logic [`TSEC_NUM_LEVELS-1:0] pend_q;
    logic [`TSEC_NUM_LEVELS-1:0] lvl_q1;
    logic [`TSEC_NUM_LEVELS-1:0] lvl_q2;
    logic gie;
    logic [31:0] pmask;
    logic [31:0] pwake;
    logic [`TSEC_ASSIGN_REGS-1:0][31:0] assign_map;
    logic wake;
  } tsec_state_t;
endpackage

/* File: hdl/tsec_top.sv */
// Two-stage event controller: peripheral routing stage, core event stage, APB registers.
//
// How it works
// - Each peripheral ID routes to a general level; software may remap through assignments.
// - Default routing sends IDs 0-2,3-4,5-8,9-14,15-18,19-28,29-31 to levels 7..13.
// - Core stage holds 9-bit latch, mask and pending registers, read at bits 7 to 15, one bit per event.
// - Latch bit sets when an event is caught and clears when it is accepted.
// - Software writes reach a latch bit only while its core mask bit is clear.
// - A set core mask bit lets its event be serviced; clear blocks but keeps latch.
// - Core mask is readable and writable only in supervisor mode.
// - Set and clear global enable instructions gate all general levels, beside masks.
// - Pending marks every active or nested event; hardware writes it, supervisor reads.
// - Routing stage holds 32-bit peripheral mask, status and wake-enable registers.
// - A set peripheral mask bit passes the ID to the core; clear blocks it.
// - Peripheral status reads one while the peripheral asserts its request.
// - An enabled peripheral raising its request while core idles asks for wake-up.
// - Several sources on one level may pulse together, before or during service.
// - Routing stage takes a pending bit turning set as the level's acknowledgement.
// - A rising edge sets the level's latch bit; detection takes two clocks.
// - The latch bit clears in the same step that sets the pending bit.
// - After pending sets, the next rising edge on that level is queued again.
// - Edge to pending takes at least three clocks, more if the core waits.
// - Lower level number wins; a higher priority event nests over a lower one.
// - Nine general levels, numbered seven to fifteen, beside the dedicated events.
`timescale 1ns/100ps
`default_nettype none
`include "tsec_defines.svh"
module tsec_top #(
  parameter int NUM_IDS = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TSEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral requests.
  input wire logic [NUM_IDS-1:0] periph_irq,
  // Processor core side.
  input wire logic supervisor_mode,
  input wire logic core_idle,
  input wire logic set_global_enable_instr,
  input wire logic clear_global_enable_instr,
  input wire logic core_accept,
  input wire logic core_return,
  output logic core_event_req,
  output logic [3:0] core_event_level,
  output logic [31:0] core_event_pending,
  output logic [`TSEC_NUM_LEVELS-1:0] level_ack,
  output logic wake_request
);
  // The registers are 32 bits, so no more than 32 IDs can be served.
  if (NUM_IDS < 1 || NUM_IDS > 32) begin : g_bad_ids
    $error("tsec_top: NUM_IDS must lie between 1 and 32");
  end

  tsec_pkg::tsec_state_t st;
  tsec_pkg::tsec_state_t next_st;
  logic [31:0] irq32;
  logic [`TSEC_NUM_LEVELS-1:0] level_raw;
  logic [`TSEC_NUM_LEVELS-1:0] rise;
  logic [`TSEC_NUM_LEVELS-1:0] armed;
  logic [3:0] cand;
  logic [3:0] top;
  logic acc_phase;
  logic wr_ok;
  logic [`TSEC_NUM_LEVELS-1:0] wlev;

  // Lowest-numbered set bit, i.e. the highest priority level, or none.
  function automatic logic [3:0] first_set(input logic [`TSEC_NUM_LEVELS-1:0] v);
    logic [3:0] idx;
    idx = `TSEC_NO_LEVEL;
    for (int i = `TSEC_NUM_LEVELS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Peripheral requests widened to the register width; missing IDs read zero.
  assign irq32 = 32'(periph_irq);

  tsec_level_map #(
    .NUM_IDS(32)
  ) u_map (
    .periph_irq(irq32),
    .peripheral_irq_mask(st.pmask),
    .assign_map(st.assign_map),
    .level_raw(level_raw)
  );

  // Edge detect over two registered stages of the level inputs.
  assign rise = st.lvl_q1 & ~st.lvl_q2;
  // Only unmasked, latched levels under the global enable compete.
  assign armed = st.gie ? (st.latch & st.mask) : '0;
  assign cand = first_set(armed);
  assign top = first_set(st.pend);
  // A candidate must outrank everything already active so that it nests over it.
  assign core_event_req = (cand != `TSEC_NO_LEVEL) && (cand < top);
  assign core_event_level = 4'(cand + 4'(`TSEC_LEVEL_BASE));
  // Pending sits at bit positions seven through fifteen of the core word.
  assign core_event_pending = 32'({st.pend, 7'h00});
  // A pending bit turning set is the acknowledgement seen by the routing stage.
  assign level_ack = st.pend & ~st.pend_q;
  assign wake_request = st.wake;

  // APB answers after one wait cycle, so read data always comes from flops.
  assign acc_phase = psel & penable;
  assign pready = acc_phase & (st.bus == tsec_pkg::TSEC_BUS_ANSWER);
  assign prdata = st.prdata;
  assign pslverr = pready & st.pslverr;
  assign wr_ok = pready & pwrite & ~st.pslverr;
  assign wlev = pwdata[`TSEC_LEVEL_BASE +: `TSEC_NUM_LEVELS];

  // Next-state logic for bus, routing stage and core stage.
  always_comb begin
    next_st = st;
    next_st.pend_q = st.pend;
    next_st.lvl_q1 = level_raw;
    next_st.lvl_q2 = st.lvl_q1;
    next_st.wake = core_idle & (|(irq32 & st.pwake));

    // Bus phase: decode and capture read data in the wait cycle.
    if (acc_phase && st.bus == tsec_pkg::TSEC_BUS_WAIT) begin
      next_st.bus = tsec_pkg::TSEC_BUS_ANSWER;
      next_st.prdata = '0;
      next_st.pslverr = 1'b0;
      case (paddr)
        `TSEC_OFF_LATCH, `TSEC_OFF_MASK, `TSEC_OFF_PEND: begin
          // Core registers are hidden outside supervisor mode.
          if (!supervisor_mode) begin
            next_st.pslverr = 1'b1;
          end else if (paddr == `TSEC_OFF_LATCH) begin
            next_st.prdata = core_latch_word(st.latch);
          end else if (paddr == `TSEC_OFF_MASK) begin
            next_st.prdata = core_latch_word(st.mask);
          end else begin
            next_st.prdata = core_event_pending;
            next_st.pslverr = pwrite;
          end
        end
        `TSEC_OFF_PMASK: begin
          next_st.prdata = st.pmask;
        end
        `TSEC_OFF_PSTAT: begin
          next_st.prdata = irq32;
          next_st.pslverr = pwrite;
        end
        `TSEC_OFF_PWAKE: begin
          next_st.prdata = st.pwake;
        end
        `TSEC_OFF_GIE: begin
          next_st.prdata = 32'(st.gie);
          next_st.pslverr = pwrite;
        end
        `TSEC_OFF_ASSIGN0: begin
          next_st.prdata = st.assign_map[0];
        end
        `TSEC_OFF_ASSIGN1: begin
          next_st.prdata = st.assign_map[1];
        end
        `TSEC_OFF_ASSIGN2: begin
          next_st.prdata = st.assign_map[2];
        end
        `TSEC_OFF_ASSIGN3: begin
          next_st.prdata = st.assign_map[3];
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end else if (!acc_phase) begin
      next_st.bus = tsec_pkg::TSEC_BUS_WAIT;
    end else if (pready) begin
      next_st.bus = tsec_pkg::TSEC_BUS_WAIT;
    end

    // Register writes land only at the answering edge.
    if (wr_ok) begin
      case (paddr)
        `TSEC_OFF_LATCH: begin
          // Bits whose mask is set keep their value; the rest take the write.
          next_st.latch = (st.latch & st.mask) | (wlev & ~st.mask);
        end
        `TSEC_OFF_MASK: begin
          next_st.mask = wlev;
        end
        `TSEC_OFF_PMASK: begin
          next_st.pmask = pwdata;
        end
        `TSEC_OFF_PWAKE: begin
          next_st.pwake = pwdata;
        end
        `TSEC_OFF_ASSIGN0: begin
          next_st.assign_map[0] = pwdata;
        end
        `TSEC_OFF_ASSIGN1: begin
          next_st.assign_map[1] = pwdata;
        end
        `TSEC_OFF_ASSIGN2: begin
          next_st.assign_map[2] = pwdata;
        end
        `TSEC_OFF_ASSIGN3: begin
          next_st.assign_map[3] = pwdata;
        end
        default: begin
          next_st.pmask = next_st.pmask;
        end
      endcase
    end

    // Global enable follows the two instructions; set wins when both arrive.
    if (set_global_enable_instr) begin
      next_st.gie = 1'b1;
    end else if (clear_global_enable_instr) begin
      next_st.gie = 1'b0;
    end

    // Returning from service retires the innermost active level.
    if (core_return && top != `TSEC_NO_LEVEL) begin
      next_st.pend[top] = 1'b0;
    end

    // Acceptance moves the event from latch to pending in one step.
    if (core_accept && core_event_req) begin
      next_st.pend[cand] = 1'b1;
      next_st.latch[cand] = 1'b0;
    end

    // A new edge sets the latch last, so it survives a same-cycle clear.
    next_st.latch = next_st.latch | rise;
  end

  // Places a level vector at bit positions seven to fifteen.
  function automatic logic [31:0] core_latch_word(input logic [`TSEC_NUM_LEVELS-1:0] v);
    return 32'({v, 7'h00});
  endfunction

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st.bus <= tsec_pkg::TSEC_BUS_WAIT;
      st.prdata <= `TSEC_RST_WORD;
      st.pslverr <= 1'b0;
      st.latch <= `TSEC_RST_LEVELS;
      st.mask <= `TSEC_RST_LEVELS;
      st.pend <= `TSEC_RST_LEVELS;
      st.pend_q <= `TSEC_RST_LEVELS;
      st.lvl_q1 <= `TSEC_RST_LEVELS;
      st.lvl_q2 <= `TSEC_RST_LEVELS;
      st.gie <= `TSEC_RST_GIE;
      st.pmask <= `TSEC_RST_WORD;
      st.pwake <= `TSEC_RST_WORD;
      st.assign_map[0] <= `TSEC_RST_ASSIGN0;
      st.assign_map[1] <= `TSEC_RST_ASSIGN1;
      st.assign_map[2] <= `TSEC_RST_ASSIGN2;
      st.assign_map[3] <= `TSEC_RST_ASSIGN3;
      st.wake <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Checks on the controller's own outputs. They live beside the logic so that every
  // bench that builds the controller runs them without further wiring.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Routing stage: reset map, peripheral mask and the source of every level.
  chk_default_route: assert property ($past(srst) |->
    st.assign_map[0] == `TSEC_RST_ASSIGN0 && st.assign_map[1] == `TSEC_RST_ASSIGN1 &&
    st.assign_map[2] == `TSEC_RST_ASSIGN2 && st.assign_map[3] == `TSEC_RST_ASSIGN3)
    else $error("Assignment registers not at default routing after reset.");
  chk_periph_block: assert property (st.pmask == '0 |-> level_raw == '0)
    else $error("Masked peripheral reached a core level.");
  chk_level_source: assert property (level_raw != '0 |-> (irq32 & st.pmask) != '0)
    else $error("Core level raised with no unmasked peripheral request.");

  // Core stage: edge capture and the hand-over from latch to pending.
  chk_latch_on_edge: assert property ((rise != '0) |=>
    ((st.latch & $past(rise)) == $past(rise)))
    else $error("Rising edge did not set its latch bit.");
  chk_accept_moves: assert property (core_accept && core_event_req && !rise[cand]
    |=> st.pend[$past(cand)] && !st.latch[$past(cand)])
    else $error("Accepted event did not move from latch to pending.");
  chk_masked_write: assert property (wr_ok && paddr == `TSEC_OFF_LATCH && rise == '0
    && !core_accept |=> (st.latch & $past(st.mask)) == ($past(st.latch) & $past(st.mask)))
    else $error("Software write changed a latch bit whose mask is set.");
  // Pending must stay clear for two edges after a fresh edge; the third may set it.
  chk_min_latency: assert property ($rose(level_raw[0]) && !st.latch[0] && !st.pend[0]
    |=> !st.pend[0] ##1 !st.pend[0])
    else $error("Pending asserted sooner than three clocks after an edge.");

  // Offer, nesting and retirement.
  chk_req_gated: assert property (core_event_req |->
    st.gie && st.latch[cand] && st.mask[cand])
    else $error("Request raised for a masked or disabled level.");
  // Checked on the result rather than on the request term, which would hold by itself.
  chk_nest_priority: assert property (core_accept && core_event_req |=>
    top == $past(cand))
    else $error("Accepted event did not become the innermost active level.");
  chk_return_retires: assert property (core_return && top != `TSEC_NO_LEVEL
    && !(core_accept && core_event_req) |=> !st.pend[$past(top)])
    else $error("Return did not retire the innermost active level.");
  chk_ack_pulse: assert property (core_accept && core_event_req |=>
    level_ack[$past(cand)])
    else $error("No acknowledgement pulse when a pending bit became set.");

  // Global enable instructions.
  chk_gie_set: assert property (set_global_enable_instr |=> st.gie)
    else $error("Set global enable instruction did not enable the levels.");
  chk_gie_clear: assert property (clear_global_enable_instr && !set_global_enable_instr
    |=> !st.gie)
    else $error("Clear global enable instruction did not disable the levels.");

  // Register bus and the wake-up path.
  chk_status_live: assert property (acc_phase && !pready && paddr == `TSEC_OFF_PSTAT
    |=> prdata == $past(irq32))
    else $error("Peripheral status did not return the live request lines.");
  chk_mask_supervisor: assert property (pready && pwrite && !supervisor_mode
    && paddr == `TSEC_OFF_MASK |=> $stable(st.mask))
    else $error("Core mask changed outside supervisor mode.");
  chk_pend_readonly: assert property (pready && pwrite && paddr == `TSEC_OFF_PEND
    |-> pslverr)
    else $error("Write to the pending register was not refused.");
  chk_wake_request: assert property (core_idle && (irq32 & st.pwake) != '0
    |=> wake_request)
    else $error("No wake request for an enabled peripheral while idle.");
  chk_wake_idle_off: assert property (!core_idle |=> !wake_request)
    else $error("Wake request raised while the core was not idle.");

  // Main scenarios that the bench is expected to reach.
  cov_accept: cover property (core_accept && core_event_req);
  cov_nest: cover property (core_accept && core_event_req && top != `TSEC_NO_LEVEL);
  cov_wake: cover property (wake_request);
  cov_requeue: cover property (rise != '0 && (st.pend & rise) != '0);
  cov_refused: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* File: testbench/tsec_core_model.sv */
// Behavioural model of the processor pipeline that takes and retires offered events.
`timescale 1ns/100ps
`default_nettype none
module tsec_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Offer from the controller and the stall wanted by the bench.
  input wire logic core_event_req,
  input wire logic [3:0] accept_delay,
  // Take and retire strobes.
  output logic core_accept,
  output logic core_return
);
  int wait_cnt;
  int active;
  int hold;
  // An offer is taken only after it has stood for the stall, so slow cores are covered too.
  assign core_accept = core_event_req && (wait_cnt >= int'(accept_delay));
  // Each handler runs a few cycles, then retires; one retire per pulse, innermost first.
  always @(posedge clk) begin
    if (srst) begin
      wait_cnt <= 0;
      active <= 0;
      hold <= 0;
      core_return <= 1'b0;
    end else begin
      wait_cnt <= (core_event_req && !core_accept) ? wait_cnt + 1 : 0;
      core_return <= (active > 0) && (hold == 5);
      hold <= (active > 0 && hold < 5) ? hold + 1 : 0;
      active <= active + int'(core_accept) - int'(core_return);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/two_stage_event_controller_tb.sv */
// Self-checking bench of the two-stage event controller, driven by a behavioural core model.
`timescale 1ns/100ps
`default_nettype none
`include "tsec_defines.svh"
module two_stage_event_controller_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`TSEC_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] periph_irq = 32'h0000_0000;
  logic supervisor_mode = 1'b1;
  logic core_idle = 1'b0;
  logic set_gie = 1'b0;
  logic clr_gie = 1'b0;
  logic [3:0] accept_delay = 4'h0;
  logic [31:0] prdata, core_event_pending, rd, v, w;
  logic pready, pslverr, core_event_req, core_accept, core_return, wake_request, err;
  logic [3:0] core_event_level;
  logic [8:0] level_ack;
  int num_errors = 0;
  int samples_checked = 0;
  int map_lvl [32];

  // Free-running system clock.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  tsec_top #(.NUM_IDS(32)) dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq),
    .supervisor_mode(supervisor_mode), .core_idle(core_idle),
    .set_global_enable_instr(set_gie), .clear_global_enable_instr(clr_gie),
    .core_accept(core_accept), .core_return(core_return), .core_event_req(core_event_req),
    .core_event_level(core_event_level), .core_event_pending(core_event_pending),
    .level_ack(level_ack), .wake_request(wake_request));

  tsec_core_model core (.clk(sys_clk), .srst(srst), .core_event_req(core_event_req),
    .accept_delay(accept_delay), .core_accept(core_accept), .core_return(core_return));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; pready, read data and error are all taken at the same rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic pulse_gie(input logic on);
    @(posedge sys_clk);
    set_gie <= on;
    clr_gie <= !on;
    @(posedge sys_clk);
    set_gie <= 1'b0;
    clr_gie <= 1'b0;
  endtask

  // Bounded wait for an exact pending pattern; returns the cycles spent.
  task automatic wait_until(input logic [31:0] exp, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (core_event_pending !== exp && n < 80);
    check(core_event_pending, exp);
  endtask

  // Raise sources, expect one event on the given level, then drop them and drain.
  task automatic fire(input logic [31:0] ids, input int lvl);
    int n;
    @(posedge sys_clk);
    periph_irq <= ids;
    accept_delay <= 4'($urandom_range(0, 3));
    wait_until(32'h0000_0001 << lvl, n);
    check(32'(level_ack), 32'h0000_0001 << (lvl - `TSEC_LEVEL_BASE));
    check(32'(n >= 4), 32'h0000_0001);
    @(posedge sys_clk);
    periph_irq <= 32'h0000_0000;
    wait_until(32'h0000_0000, n);
  endtask

  function automatic logic [31:0] map_word(input int r);
    map_word = 32'h0000_0000;
    for (int k = 0; k < 8; k++) map_word[4*k +: 4] = 4'(map_lvl[8*r+k] - 7);
  endfunction

  // Hang guard, far beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    int n;
    void'($urandom(44));
    for (int i = 0; i < 32; i++) begin
      map_lvl[i] = i < 3 ? 7 : i < 5 ? 8 : i < 9 ? 9 : i < 15 ? 10 :
                   i < 19 ? 11 : i < 29 ? 12 : 13;
    end
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (int r = 0; r < 4; r++) rd_chk(`TSEC_OFF_ASSIGN0 + 12'(4 * r), map_word(r));
    for (int a = 0; a <= 24; a += 4) rd_chk(12'(a), 32'h0000_0000);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    $display("reset test finished");
    apb(1'b1, `TSEC_OFF_PMASK, 32'hFFFF_FFFF);
    apb(1'b1, `TSEC_OFF_MASK, 32'h0000_FF80);
    pulse_gie(1'b1);
    for (int i = 0; i < 32; i++) fire(32'h0000_0001 << i, map_lvl[i]);
    fire(32'h0000_0006, 7);
    map_lvl[0] = 15;
    apb(1'b1, `TSEC_OFF_ASSIGN0, map_word(0));
    fire(32'h0000_0001, 15);
    $display("routing test finished");
    apb(1'b1, `TSEC_OFF_PMASK, 32'hFFFF_FFF7);
    @(posedge sys_clk);
    periph_irq <= 32'h0000_0008;
    repeat (10) @(negedge sys_clk);
    check(core_event_pending, 32'h0000_0000);
    rd_chk(`TSEC_OFF_LATCH, 32'h0000_0000);
    periph_irq <= 32'h0000_0000;
    apb(1'b1, `TSEC_OFF_PMASK, 32'hFFFF_FFFF);
    pulse_gie(1'b0);
    apb(1'b1, `TSEC_OFF_MASK, 32'h0000_0000);
    apb(1'b1, `TSEC_OFF_LATCH, 32'h0000_8080);
    rd_chk(`TSEC_OFF_LATCH, 32'h0000_8080);
    apb(1'b1, `TSEC_OFF_MASK, 32'h0000_8000);
    apb(1'b1, `TSEC_OFF_LATCH, 32'h0000_0000);
    rd_chk(`TSEC_OFF_LATCH, 32'h0000_8000);
    apb(1'b1, `TSEC_OFF_PEND, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
    rd_chk(`TSEC_OFF_PEND, 32'h0000_0000);
    pulse_gie(1'b1);
    wait_until(32'h0000_8000, n);
    rd_chk(`TSEC_OFF_LATCH, 32'h0000_0000);
    wait_until(32'h0000_0000, n);
    $display("latch test finished");
    pulse_gie(1'b0);
    apb(1'b1, `TSEC_OFF_MASK, 32'h0000_FF80);
    @(posedge sys_clk);
    periph_irq <= 32'h2000_0008;
    rd_chk(`TSEC_OFF_LATCH, 32'h0000_2100);
    periph_irq <= 32'h0000_0000;
    pulse_gie(1'b1);
    wait_until(32'h0000_0100, n);
    wait_until(32'h0000_2000, n);
    wait_until(32'h0000_0000, n);
    // A higher-priority level arriving while a lower-priority one is active must nest over it.
    @(posedge sys_clk);
    periph_irq <= 32'h2000_0000;
    accept_delay <= 4'h0;
    wait_until(32'h0000_2000, n);
    @(posedge sys_clk);
    periph_irq <= 32'h2000_0008;
    wait_until(32'h0000_2100, n);
    @(posedge sys_clk);
    periph_irq <= 32'h0000_0000;
    wait_until(32'h0000_0000, n);
    @(posedge sys_clk);
    supervisor_mode <= 1'b0;
    apb(1'b1, `TSEC_OFF_MASK, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    supervisor_mode <= 1'b1;
    rd_chk(`TSEC_OFF_MASK, 32'h0000_FF80);
    $display("priority test finished");
    apb(1'b1, `TSEC_OFF_PMASK, 32'h0000_0000);
    v = $urandom;
    w = $urandom;
    apb(1'b1, `TSEC_OFF_PWAKE, w);
    rd_chk(`TSEC_OFF_PWAKE, w);
    periph_irq <= v;
    core_idle <= 1'b1;
    rd_chk(`TSEC_OFF_PSTAT, v);
    check(32'(wake_request), 32'(|(v & w)));
    core_idle <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check(32'(wake_request), 32'h0000_0000);
    $display("status test finished");
    complete_run();
  end
endmodule
`default_nettype wire
